/* File: rtl/acrb_pkg.sv */
// Purpose: constants and carrier types of the converter config register bank
// Assumes: 16-clock serial frames, word = address, write flag, data byte
// Notes: frame layout is [15:9] address, [8] write, [7:0] data
package acrb_pkg;

  localparam int ACRB_FRAME_BITS = 16;
  localparam int ACRB_CHANNELS = 4;

  // register offsets
  localparam logic [6:0] ACRB_OFS_IDLE = 7'h00;
  localparam logic [6:0] ACRB_OFS_RESET = 7'h01;
  localparam logic [6:0] ACRB_OFS_MANUAL = 7'h04;
  localparam logic [6:0] ACRB_OFS_AUTO = 7'h05;
  localparam logic [6:0] ACRB_OFS_AUX = 7'h06;
  localparam logic [6:0] ACRB_OFS_SCAN_SEL = 7'h0c;
  localparam logic [6:0] ACRB_OFS_RANGE_BASE = 7'h10;
  localparam logic [6:0] ACRB_OFS_RANGE_LAST = 7'h13;

  // values after reset
  localparam logic [7:0] ACRB_RST_RESET_CTRL = 8'h00;
  localparam logic [7:0] ACRB_RST_AUX = 8'h00;
  localparam logic [7:0] ACRB_RST_SCAN_SEL = 8'h00;
  localparam logic [2:0] ACRB_RST_RANGE = 3'h1;
  localparam logic [1:0] ACRB_RST_CHANNEL = 2'h0;

  // field positions and masks
  localparam int ACRB_RESET_REQ_BIT = 0;
  localparam int ACRB_AUX_PIN_ROLE_BIT = 3;
  localparam int ACRB_AUX_VREF_BIT = 2;
  localparam int ACRB_AUX_TEMP_BIT = 1;
  localparam logic [7:0] ACRB_AUX_MASK = 8'h0e;
  localparam logic [7:0] ACRB_SCAN_SEL_MASK = 8'haa;
  localparam int ACRB_SCAN_CH0_BIT = 7;
  localparam int ACRB_MODE_SEQ_RESET_BIT = 7;
  localparam int ACRB_MODE_CHAN_LSB = 5;
  localparam int ACRB_MODE_RANGE_LSB = 1;
  localparam int ACRB_MODE_TEMP_BIT = 0;
  localparam int ACRB_RANGE_FIELD_LSB = 4;

  // range codes
  localparam logic [2:0] ACRB_RANGE_TABLE = 3'h0;
  localparam logic [2:0] ACRB_RANGE_BIP_10V = 3'h1;
  localparam logic [2:0] ACRB_RANGE_BIP_5V = 3'h2;
  localparam logic [2:0] ACRB_RANGE_BIP_2V5 = 3'h3;
  localparam logic [2:0] ACRB_RANGE_RSV4 = 3'h4;
  localparam logic [2:0] ACRB_RANGE_UNI_10V = 3'h5;
  localparam logic [2:0] ACRB_RANGE_UNI_5V = 3'h6;
  localparam logic [2:0] ACRB_RANGE_RSV7 = 3'h7;

  // synchroniser depth
  localparam int ACRB_SYNC_STAGES = 2;

  typedef enum logic {ACRB_MODE_MANUAL, ACRB_MODE_AUTO} acrb_mode_type;

  typedef struct packed {
    logic [6:0] addr;
    logic write;
    logic [7:0] data;
  } acrb_frame_type;

  typedef struct packed {
    logic auto_mode;
    logic temp_sel;
    logic [1:0] channel;
    logic [2:0] range;
  } acrb_conv_type;

endpackage

/* File: rtl/acrb_frame_rx.sv */
// Purpose: link-side shifter of the 16-clock serial frame
// Assumes: data sampled and shifted on falling sclk edges while cs_n is low
// Notes: a frame counts only after its 16th falling edge
`timescale 1ns/10ps
module acrb_frame_rx
  import acrb_pkg::*;
(
  input wire logic sclk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic din,
  input wire logic [7:0] read_byte,
  output acrb_frame_type frame_word,
  output logic frame_toggle,
  output logic sdo
);

  logic [3:0] bit_count;
  logic [ACRB_FRAME_BITS-2:0] shift;
  wire last_edge = (bit_count == 4'hf);
  wire [2:0] out_index = 3'h7 - bit_count[2:0];

  // a deasserted select discards any partial frame
  always_ff @(negedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      bit_count <= 4'h0;
      shift <= '0;
      sdo <= 1'b0;
    end
    else
    begin
      bit_count <= bit_count + 4'h1;
      shift <= {shift[ACRB_FRAME_BITS-3:0], din};
      sdo <= bit_count[3] ? 1'b0 : read_byte[out_index];
    end
  end

  // word is held until the next complete frame
  always_ff @(negedge sclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      frame_word <= '0;
      frame_toggle <= 1'b0;
    end
    else if (last_edge)
    begin
      frame_word <= {shift, din};
      frame_toggle <= ~frame_toggle;
    end
  end

endmodule

/* File: rtl/acrb_config_bank.sv */
// Purpose: configuration register bank and scan sequencer of a SAR converter
// Assumes: frames arrive from acrb_frame_rx on the serial clock domain
// Notes: one committed frame is one conversion frame, except a frame that requests a software reset
`timescale 1ns/10ps
module acrb_config_bank
  import acrb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic sdo,
  input wire logic alarm_level,
  input wire logic alarm_or_powerdown_pin_in,
  output logic alarm_or_powerdown_pin_out,
  output logic alarm_or_powerdown_pin_oe,
  output logic powerdown_request,
  output logic vref_power_up,
  output logic temp_sensor_power_up,
  output acrb_conv_type conv,
  output logic conv_strobe
);

  acrb_frame_type link_word;
  logic link_toggle;
  logic [7:0] read_byte;

  acrb_frame_rx u_frame_rx (
    .sclk(sclk),
    .rst_n(rst_n),
    .cs_n(cs_n),
    .din(din),
    .read_byte(read_byte),
    .frame_word(link_word),
    .frame_toggle(link_toggle),
    .sdo(sdo)
  );

  // frame event crossing: toggle through two flops, then edge detect
  logic toggle_meta;
  logic toggle_sync;
  logic toggle_seen;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      toggle_meta <= 1'b0;
      toggle_sync <= 1'b0;
      toggle_seen <= 1'b0;
    end
    else
    begin
      toggle_meta <= link_toggle;
      toggle_sync <= toggle_meta;
      toggle_seen <= toggle_sync;
    end
  end

  // word is stable for a whole frame after the toggle flips
  wire commit = toggle_sync ^ toggle_seen;
  acrb_frame_type word;
  assign word = link_word;

  // registers
  logic [7:0] reset_ctrl;
  logic [7:0] aux_ctrl;
  logic [7:0] scan_select;
  logic [2:0] range_reg [ACRB_CHANNELS];
  acrb_mode_type mode;
  logic temp_sticky;
  logic [1:0] channel;

  // frame decode
  wire idle_frame = (word == '0);
  wire is_write = word.write && !idle_frame;
  wire is_read = !word.write && !idle_frame;
  wire wr_reset = commit && is_write && (word.addr == ACRB_OFS_RESET);
  wire wr_manual = commit && is_write && (word.addr == ACRB_OFS_MANUAL);
  wire wr_auto = commit && is_write && (word.addr == ACRB_OFS_AUTO);
  wire wr_aux = commit && is_write && (word.addr == ACRB_OFS_AUX);
  wire wr_scan = commit && is_write && (word.addr == ACRB_OFS_SCAN_SEL);
  wire wr_range_any = commit && is_write &&
    (word.addr >= ACRB_OFS_RANGE_BASE) && (word.addr <= ACRB_OFS_RANGE_LAST);
  wire [6:0] range_offset = word.addr - ACRB_OFS_RANGE_BASE;
  wire [1:0] range_index = range_offset[1:0];
  wire sw_reset = wr_reset && word.data[ACRB_RESET_REQ_BIT];

  wire [2:0] new_range = word.data[ACRB_RANGE_FIELD_LSB +: 3];
  wire range_code_ok = (new_range != ACRB_RANGE_TABLE) &&
    (new_range != ACRB_RANGE_RSV4) && (new_range != ACRB_RANGE_RSV7);

  // channel enables from the odd bits only
  logic [ACRB_CHANNELS-1:0] scan_en_raw;
  logic [ACRB_CHANNELS-1:0] scan_en;

  genvar g;
  generate
    for (g = 0; g < ACRB_CHANNELS; g = g + 1)
    begin : g_scan_en
      assign scan_en_raw[g] = scan_select[ACRB_SCAN_CH0_BIT-2*g];
    end
  endgenerate

  assign scan_en = (scan_en_raw == '0) ? 4'h1 : scan_en_raw;

  // lowest enabled channel
  function automatic logic [1:0] lowest_enabled(
    input logic [ACRB_CHANNELS-1:0] en
  );
    logic [1:0] pick;
    pick = 2'h0;
    for (int i = ACRB_CHANNELS - 1; i >= 0; i--)
    begin
      if (en[i])
      begin
        pick = 2'(i);
      end
    end
    return pick;
  endfunction

  // next enabled channel above cur, else wrap to the lowest
  function automatic logic [1:0] next_enabled(
    input logic [ACRB_CHANNELS-1:0] en,
    input logic [1:0] cur
  );
    logic [1:0] pick;
    logic found;
    pick = lowest_enabled(en);
    found = 1'b0;
    for (int i = 0; i < ACRB_CHANNELS; i++)
    begin
      if (!found && en[i] && (2'(i) > cur))
      begin
        pick = 2'(i);
        found = 1'b1;
      end
    end
    return pick;
  endfunction

  // sequencing for the frame that follows the committed one
  acrb_mode_type next_mode;
  logic next_temp;
  logic [1:0] next_channel;
  logic [2:0] next_override;

  wire [2:0] frame_range = word.data[ACRB_MODE_RANGE_LSB +: 3];
  wire frame_temp = word.data[ACRB_MODE_TEMP_BIT];

  always_comb
  begin
    next_mode = mode;
    next_temp = temp_sticky;
    next_channel = channel;
    next_override = ACRB_RANGE_TABLE;
    if (wr_manual)
    begin
      next_mode = ACRB_MODE_MANUAL;
      next_temp = frame_temp;
      next_channel = word.data[ACRB_MODE_CHAN_LSB +: 2];
      next_override = frame_range;
    end
    else if (wr_auto)
    begin
      next_mode = ACRB_MODE_AUTO;
      next_temp = frame_temp;
      next_override = frame_range;
      if (word.data[ACRB_MODE_SEQ_RESET_BIT])
      begin
        next_channel = lowest_enabled(scan_en);
      end
      else if (!frame_temp)
      begin
        next_channel = next_enabled(scan_en, channel);
      end
    end
    else
    begin
      // any other frame keeps mode and temperature pick
      case (mode)
        ACRB_MODE_AUTO:
        begin
          if (!temp_sticky)
          begin
            next_channel = next_enabled(scan_en, channel);
          end
        end
        ACRB_MODE_MANUAL:
        begin
          next_channel = channel;
        end
        default:
        begin
          next_channel = channel;
        end
      endcase
    end
  end

  // one-frame override only with a valid code, else per-channel table
  wire override_ok = (next_override != ACRB_RANGE_TABLE) &&
    (next_override != ACRB_RANGE_RSV4) && (next_override != ACRB_RANGE_RSV7);
  wire [2:0] next_range = override_ok ? next_override :
    range_reg[next_channel];

  acrb_conv_type next_conv;
  assign next_conv.auto_mode = (next_mode == ACRB_MODE_AUTO);
  assign next_conv.temp_sel = next_temp;
  assign next_conv.channel = next_channel;
  assign next_conv.range = next_range;

  // register file
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || sw_reset)
    begin
      reset_ctrl <= ACRB_RST_RESET_CTRL;
      aux_ctrl <= ACRB_RST_AUX;
      scan_select <= ACRB_RST_SCAN_SEL;
    end
    else
    begin
      if (wr_reset)
      begin
        reset_ctrl <= word.data & ~8'h01;
      end
      if (wr_aux)
      begin
        aux_ctrl <= word.data & ACRB_AUX_MASK;
      end
      if (wr_scan)
      begin
        scan_select <= word.data & ACRB_SCAN_SEL_MASK;
      end
    end
  end

  generate
    for (g = 0; g < ACRB_CHANNELS; g = g + 1)
    begin : g_range
      always_ff @(posedge clk_sys)
      begin
        if (!rst_n || sw_reset)
        begin
          range_reg[g] <= ACRB_RST_RANGE;
        end
        else if (wr_range_any && range_code_ok && (range_index == 2'(g)))
        begin
          range_reg[g] <= new_range;
        end
      end
    end
  endgenerate

  // scan state and conversion outputs
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || sw_reset)
    begin
      mode <= ACRB_MODE_MANUAL;
      temp_sticky <= 1'b0;
      channel <= ACRB_RST_CHANNEL;
      conv <= '0;
      conv_strobe <= 1'b0;
    end
    else
    begin
      conv_strobe <= commit;
      if (commit)
      begin
        mode <= next_mode;
        temp_sticky <= next_temp;
        channel <= next_channel;
        conv <= next_conv;
      end
    end
  end

  // readback of the addressed register for the following frame
  logic [7:0] read_mux;
  assign read_mux =
    (word.addr == ACRB_OFS_RESET) ? reset_ctrl :
    (word.addr == ACRB_OFS_AUX) ? aux_ctrl :
    (word.addr == ACRB_OFS_SCAN_SEL) ? scan_select :
    (word.addr == ACRB_OFS_RANGE_BASE) ? {1'b0, range_reg[0], 4'h0} :
    (word.addr == ACRB_OFS_RANGE_BASE + 7'h1) ? {1'b0, range_reg[1], 4'h0} :
    (word.addr == ACRB_OFS_RANGE_BASE + 7'h2) ? {1'b0, range_reg[2], 4'h0} :
    (word.addr == ACRB_OFS_RANGE_LAST) ? {1'b0, range_reg[3], 4'h0} :
    8'h00;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || sw_reset)
    begin
      read_byte <= 8'h00;
    end
    else if (commit)
    begin
      read_byte <= is_read ? read_mux : 8'h00;
    end
  end

  // auxiliary block power, taken from the register after each frame
  wire pin_is_input = aux_ctrl[ACRB_AUX_PIN_ROLE_BIT];

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      vref_power_up <= 1'b0;
      temp_sensor_power_up <= 1'b0;
    end
    else
    begin
      vref_power_up <= aux_ctrl[ACRB_AUX_VREF_BIT];
      temp_sensor_power_up <= aux_ctrl[ACRB_AUX_TEMP_BIT];
    end
  end

  // shared pin: alarm output or power-down input
  logic pin_meta;
  logic pin_sync;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end
    else
    begin
      pin_meta <= alarm_or_powerdown_pin_in;
      pin_sync <= pin_meta;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      alarm_or_powerdown_pin_out <= 1'b0;
      alarm_or_powerdown_pin_oe <= 1'b0;
      powerdown_request <= 1'b0;
    end
    else
    begin
      alarm_or_powerdown_pin_oe <= !pin_is_input;
      alarm_or_powerdown_pin_out <= pin_is_input ? 1'b0 : alarm_level;
      powerdown_request <= pin_is_input && pin_sync;
    end
  end

endmodule

/* File: testbench/acrb_config_bank_assertions.sv */
// Purpose: port-level checks of the converter config register bank
// Assumes: watches only the top ports, clocked by clk_sys
// Notes: bound from the testbench top file
`timescale 1ns/10ps
module acrb_config_bank_assertions
  import acrb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic sdo,
  input wire logic alarm_level,
  input wire logic alarm_or_powerdown_pin_in,
  input wire logic alarm_or_powerdown_pin_out,
  input wire logic alarm_or_powerdown_pin_oe,
  input wire logic powerdown_request,
  input wire logic vref_power_up,
  input wire logic temp_sensor_power_up,
  input wire acrb_conv_type conv,
  input wire logic conv_strobe
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  a_strobe_one_cycle: assert property (
    conv_strobe |=> !conv_strobe)
    else $error("conv strobe wider than one cycle");
  a_conv_only_commit: assert property ($changed(conv) |->
    conv_strobe || conv == '0)
    else $error("conv changed without a committed frame");
  a_range_code_valid: assert property (
    conv_strobe && !conv.temp_sel |->
    conv.range inside {3'h1, 3'h2, 3'h3, 3'h5, 3'h6})
    else $error("conv carries a reserved range code");
  a_role_exclusive: assert property (alarm_or_powerdown_pin_oe |->
    !powerdown_request)
    else $error("power-down request while pin is an output");
  a_pin_quiet_input: assert property (!alarm_or_powerdown_pin_oe |->
    !alarm_or_powerdown_pin_out)
    else $error("pin driven value while pin is an input");
  a_alarm_on_pin: assert property ((alarm_or_powerdown_pin_oe &&
    $stable(alarm_level))[*3] |-> alarm_or_powerdown_pin_out == alarm_level)
    else $error("alarm level not shown on the pin");
  a_powerdown_sync: assert property ((!alarm_or_powerdown_pin_oe &&
    $stable(alarm_or_powerdown_pin_in))[*5] |->
    powerdown_request == alarm_or_powerdown_pin_in)
    else $error("power-down request does not follow the pin");
  // power and role outputs follow the register one cycle after the strobe
  a_vref_on_commit: assert property ($rose(vref_power_up) |->
    $past(conv_strobe))
    else $error("reference powered up outside a frame commit");
  a_temp_on_commit: assert property (
    $rose(temp_sensor_power_up) |-> $past(conv_strobe))
    else $error("temperature sensor powered up outside a commit");
  a_role_on_commit: assert property (
    $fell(alarm_or_powerdown_pin_oe) |-> $past(conv_strobe))
    else $error("pin role changed outside a frame commit");
endmodule

/* File: testbench/acrb_host_model.sv */
// Purpose: serial host that sends n-clock frames (16 for a full frame) to the register bank
// Assumes: sclk idles high, 160 ns period only inside frames
// Notes: din shows the inverse of its last bit once released
`timescale 1ns/10ps
module acrb_host_model
(
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic sdo
);
  initial
  begin
    sclk = 1'b1;
    din = 1'b1;
    // a definite rising select clears the link bit counter
    #1 cs_n = 1'b1;
  end

  // n falling edges, msb first; rd collects the first eight sdo bits
  task automatic xfer(input logic [15:0] w, input int n,
                      output logic [7:0] rd);
    rd = 8'h00;
    #37 cs_n = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      din = w[15-i];
      #80 sclk = 1'b0;
      #80 sclk = 1'b1;
      if (i < 8)
        rd[7-i] = sdo;
    end
    din = ~din;
    #40 cs_n = 1'b1;
    #500;
  endtask
endmodule

/* File: testbench/acrb_config_bank_tb_top.sv */
// Purpose: self-checking bench of the converter config register bank
// Assumes: host model paces frames on its own serial clock
// Notes: each scenario is a task that judges its own outcome
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
  mismatches++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module acrb_config_bank_tb_top
  import acrb_pkg::*;
;
  logic clk_sys, rst_n, sclk, cs_n, din, sdo, alarm_level;
  logic pin_out, pin_oe, pd_drv, powerdown_request;
  logic vref_power_up, temp_sensor_power_up, conv_strobe;
  wire logic pin_in;
  acrb_conv_type conv;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  int strobes = 0;

  assign pin_in = pin_oe ? pin_out : pd_drv;

  acrb_config_bank i_acrb_config_bank (.clk_sys(clk_sys), .rst_n(rst_n),
    .sclk(sclk), .cs_n(cs_n), .din(din), .sdo(sdo),
    .alarm_level(alarm_level), .alarm_or_powerdown_pin_in(pin_in),
    .alarm_or_powerdown_pin_out(pin_out),
    .alarm_or_powerdown_pin_oe(pin_oe),
    .powerdown_request(powerdown_request), .vref_power_up(vref_power_up),
    .temp_sensor_power_up(temp_sensor_power_up), .conv(conv),
    .conv_strobe(conv_strobe));
  acrb_host_model i_acrb_host_model (.sclk(sclk), .cs_n(cs_n), .din(din),
    .sdo(sdo));

  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    cycles++;
    if (conv_strobe === 1'b1)
      strobes++;
    if (cycles == 20000)
    begin
      mismatches++;
      results();
    end
  end

  task automatic results;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    i_acrb_host_model.xfer({a, 1'b1, d}, 16, r);
  endtask

  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    i_acrb_host_model.xfer({a, 1'b0, 8'h00}, 16, d);
    i_acrb_host_model.xfer(16'h0000, 16, d);
  endtask

  task automatic idle;
    logic [7:0] r;
    i_acrb_host_model.xfer(16'h0000, 16, r);
  endtask

  task automatic t_aux;
    logic [7:0] r;
    int s;
    s = strobes;
    i_acrb_host_model.xfer({ACRB_OFS_AUX, 1'b1, 8'h0e}, 8, r);
    `CHK(vref_power_up, 1'b0)
    `CHK(strobes, s)
    wr(ACRB_OFS_AUX, 8'h0e);
    `CHK(strobes, s + 1)
    `CHK(vref_power_up, 1'b1)
    `CHK(temp_sensor_power_up, 1'b1)
    `CHK(pin_oe, 1'b0)
    @(negedge clk_sys) pd_drv = 1'b1;
    repeat (6) @(negedge clk_sys);
    `CHK(powerdown_request, 1'b1)
    rd(ACRB_OFS_AUX, r);
    `CHK(r, 8'h0e)
    wr(ACRB_OFS_AUX, 8'h00);
    `CHK(vref_power_up, 1'b0)
    `CHK(temp_sensor_power_up, 1'b0)
    `CHK(powerdown_request, 1'b0)
    @(negedge clk_sys) alarm_level = 1'b1;
    repeat (4) @(negedge clk_sys);
    `CHK({pin_oe, pin_out}, 2'h3)
  endtask

  task automatic t_scan;
    logic [7:0] r;
    wr(ACRB_OFS_SCAN_SEL, 8'h27);
    rd(ACRB_OFS_SCAN_SEL, r);
    `CHK(r, 8'h22)
    wr(ACRB_OFS_RANGE_LAST, 8'h60);
    wr(7'h11, 8'h70);
    rd(7'h11, r);
    `CHK(r, 8'h10)
    wr(ACRB_OFS_AUTO, 8'h84);
    `CHK(conv, {1'b1, 1'b0, 2'h1, 3'h2})
    idle();
    `CHK(conv, {1'b1, 1'b0, 2'h3, 3'h6})
    idle();
    `CHK(conv, {1'b1, 1'b0, 2'h1, 3'h1})
    wr(ACRB_OFS_SCAN_SEL, 8'h55);
    wr(ACRB_OFS_AUTO, 8'h80);
    `CHK(conv, {1'b1, 1'b0, 2'h0, 3'h1})
    idle();
    `CHK(conv, {1'b1, 1'b0, 2'h0, 3'h1})
  endtask

  task automatic t_temp_reset;
    logic [7:0] r;
    wr(ACRB_OFS_MANUAL, 8'h41);
    idle();
    `CHK({conv.auto_mode, conv.temp_sel}, 2'h1)
    wr(ACRB_OFS_AUX, 8'h06);
    `CHK(vref_power_up, 1'b1)
    wr(ACRB_OFS_RESET, 8'h01);
    `CHK(conv, 7'h00)
    `CHK({vref_power_up, temp_sensor_power_up, pin_oe}, 3'h1)
    rd(ACRB_OFS_RESET, r);
    `CHK(r, 8'h00)
    rd(ACRB_OFS_RANGE_LAST, r);
    `CHK(r, 8'h10)
  endtask

  initial
  begin
    alarm_level = 1'b0;
    pd_drv = 1'b0;
    // a definite falling edge arms the link side's asynchronous clear
    #1 rst_n = 1'b0;
    repeat (20) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    t_aux();
    t_scan();
    t_temp_reset();
    results();
  end
endmodule

bind acrb_config_bank acrb_config_bank_assertions i_acrb_config_bank_assertions
  (.clk_sys(clk_sys), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .din(din),
  .sdo(sdo), .alarm_level(alarm_level),
  .alarm_or_powerdown_pin_in(alarm_or_powerdown_pin_in),
  .alarm_or_powerdown_pin_out(alarm_or_powerdown_pin_out),
  .alarm_or_powerdown_pin_oe(alarm_or_powerdown_pin_oe),
  .powerdown_request(powerdown_request), .vref_power_up(vref_power_up),
  .temp_sensor_power_up(temp_sensor_power_up), .conv(conv),
  .conv_strobe(conv_strobe));
